// File: pkg/fpc_pkg.sv
// constants, types and helpers shared by the flash protect/program controller
// assumes one 50 MHz clock domain; byte addresses on the register port
// Operation
// R1: program/erase on protected block flags access
// R2: finished program or erase flags completion
// R3: eeprom interrupt forwarded as own flag
// R4: bad supply aborts operation, flags voltage
// R5: clearing-only violation flags data error
// R6: failed erase flags erase error
// R7: failed program flags program error
// R8: per-source enables gate the interrupt line
// R9: raw and masked flags both readable
// R10: data read of fetch-only block refused
// R11: software programs aligned 32-bit words only
// R12: three protection levels enforced
// R13: protection may only tighten
// R14: loosening attempts blocked, setting kept
// R15: uncommitted protection reverts on reset
// R16: protection commit stored, finish signalled
// R17: two readable writable user registers
// R18: user commit makes values permanent
// R19: busy and finished shown to software
// R20: erase leaves block all ones
// R21: programming only clears bits
// R22: clear request drops named flags
// R23: misaligned erase address rejected as error
package fpc_pkg;
  localparam int NBLK = 8;
  localparam int BLK_W = 3;
  localparam int BLK_LSB = 10;
  localparam int ADDR_TOP = 13;
  localparam int NFLAG = 7;
  // register offsets
  localparam logic [7:0] REG_ADDR = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_RAW = 8'h10;
  localparam logic [7:0] REG_MASKED = 8'h14;
  localparam logic [7:0] REG_IEN = 8'h18;
  localparam logic [7:0] REG_ICLR = 8'h1C;
  localparam logic [7:0] REG_PROT = 8'h20;
  localparam logic [7:0] REG_USER0 = 8'h24;
  localparam logic [7:0] REG_USER1 = 8'h28;
  // command bits
  localparam int CMD_PROG = 0;
  localparam int CMD_ERASE = 1;
  localparam int CMD_PSAVE = 2;
  localparam int CMD_USAVE = 3;
  // protect register write fields
  localparam int PROT_BLK_LSB = 8;
  // status bits
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_ULOCK = 3;
  // interrupt flag positions
  localparam int FL_ACCESS = 0;
  localparam int FL_DONE = 1;
  localparam int FL_EEPROM = 2;
  localparam int FL_VOLT = 3;
  localparam int FL_DATA = 4;
  localparam int FL_ERASE = 5;
  localparam int FL_PROG = 6;
  // protection levels
  localparam logic [1:0] PROTECT_LEVEL_OPEN = 2'h0;
  localparam logic [1:0] PROTECT_LEVEL_NOWRITE = 2'h1;
  localparam logic [1:0] PROTECT_LEVEL_FETCH_ONLY = 2'h2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [NFLAG-1:0] RESET_FLAGS = 7'h00;

  // request to the flash array macro
  typedef struct packed {
    logic req;
    logic erase;
    logic abort;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fpc_fa_req_t;

  // block index of a byte address
  function automatic logic [BLK_W-1:0] fpc_blk(input logic [31:0] a);
    return a[BLK_LSB+BLK_W-1:BLK_LSB];
  endfunction

  // address lies inside the array
  function automatic logic fpc_in_range(input logic [31:0] a);
    return a[31:ADDR_TOP] == 19'h0_0000;
  endfunction
endpackage

// File: verif/fpc_ctrl_monitor.sv
// checker on fpc_ctrl ports: array requests, aborts, read strobes
// assumes one clk domain and rstn active low asynchronous
`timescale 1ns/1ps
module fpc_ctrl_monitor import fpc_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata_r,
  input wire fpc_fa_req_t fa_r,
  input wire logic [31:0] fa_rdata,
  input wire logic fa_done,
  input wire logic supply_bad,
  input wire logic dr_req,
  input wire logic dr_deny_r,
  input wire logic nv_req_r
);
  logic op_run_r;
  logic [7:0] sb_hist_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // array operation in flight and recent supply history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_run_r <= 1'h0;
      sb_hist_r <= 8'h00;
    end else begin
      op_run_r <= fa_r.req | (op_run_r & ~fa_done & ~fa_r.abort);
      sb_hist_r <= {sb_hist_r[6:0], supply_bad};
    end
  end
  sequence s_prog;
    fa_r.req && !fa_r.erase;
  endsequence
  sequence s_erase;
    fa_r.req && fa_r.erase;
  endsequence
  sequence s_bad_run;
    op_run_r && supply_bad;
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata_r == 32'h0000_0000)
    else $error("read data outside read cycle");
  deny_cause_a: assert property (dr_deny_r |-> $past(dr_req))
    else $error("deny without data read");
  prog_align_a: assert property (s_prog |-> fa_r.addr[1:0] == 2'h0 && fpc_in_range(fa_r.addr))
    else $error("program address not a word in array");
  erase_align_a: assert property (s_erase |-> fa_r.addr[9:0] == 10'h000 && fpc_in_range(fa_r.addr))
    else $error("erase address not a block start");
  prog_clears_a: assert property (s_prog |-> (fa_r.wdata & ~fa_rdata) == 32'h0000_0000)
    else $error("program would set a bit");
  one_op_a: assert property (op_run_r |-> !fa_r.req && !nv_req_r)
    else $error("request while array busy");
  abort_due_a: assert property (s_bad_run |-> ##[0:8] fa_r.abort)
    else $error("no abort on bad supply");
  abort_cause_a: assert property (fa_r.abort |-> sb_hist_r != 8'h00)
    else $error("abort without bad supply");
  req_abort_a: assert property (!(fa_r.req && fa_r.abort))
    else $error("start and abort together");
endmodule
bind fpc_ctrl fpc_ctrl_monitor mon_u (.clk(clk), .rstn(rstn), .reg_rd(reg_rd),
  .reg_rdata_r(reg_rdata_r), .fa_r(fa_r), .fa_rdata(fa_rdata), .fa_done(fa_done),
  .supply_bad(supply_bad), .dr_req(dr_req), .dr_deny_r(dr_deny_r), .nv_req_r(nv_req_r));

// File: verif/fpc_flash_model.sv
// partner model: flash array words and nonvolatile commit store
// assumes fpc_ctrl drives fa and nv requests from clk flops
`timescale 1ns/1ps
module fpc_flash_model import fpc_pkg::*; (
  input wire logic clk,
  input wire fpc_fa_req_t fa,
  input wire logic fail,
  input wire logic [3:0] lat,
  output logic [31:0] fa_rdata,
  output logic fa_done,
  output logic fa_ok,
  input wire logic nv_req,
  input wire logic nv_sel,
  input wire logic [63:0] nv_wdata,
  output logic nv_done,
  output logic [15:0] nv_prot,
  output logic [31:0] nv_user0,
  output logic [31:0] nv_user1
);
  logic [31:0] mem [2048];
  fpc_fa_req_t op;
  int cnt = 0;
  // array read follows the address at once
  assign fa_rdata = mem[fa.addr[12:2]];
  // stored state: block 7 nowrite, user words arbitrary
  initial begin
    foreach (mem[i]) mem[i] = 32'h0000_0000;
    fa_done = 1'h0;
    fa_ok = 1'h0;
    nv_done = 1'h0;
    nv_prot = 16'h4000;
    nv_user0 = 32'h0000_00A5;
    nv_user1 = 32'h0000_005A;
  end
  // timed array operation, ok line toggles outside done
  always @(posedge clk) begin
    fa_done <= 1'h0;
    fa_ok <= ~fa_ok;
    nv_done <= nv_req;
    if (nv_req && nv_sel) {nv_user1, nv_user0} <= nv_wdata;
    if (nv_req && !nv_sel) nv_prot <= nv_wdata[15:0];
    if (fa.req) begin
      op <= fa;
      cnt <= lat + 1;
    end else if (fa.abort) begin
      cnt <= 0;
    end else if (cnt == 1) begin
      cnt <= 0;
      fa_done <= 1'h1;
      fa_ok <= !fail;
      if (!fail && op.erase) begin
        for (int i = 0; i < 256; i++) mem[{op.addr[12:10], i[7:0]}] <= 32'hFFFF_FFFF;
      end
      if (!fail && !op.erase) mem[op.addr[12:2]] <= mem[op.addr[12:2]] & op.wdata;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// File: verif/test_flash_protect_program_ctrl.sv
// self-checking bench for fpc_ctrl with array and nv store model
// assumes fpc_flash_model and the bound checker are compiled first
`timescale 1ns/1ps
module test_flash_protect_program_ctrl import fpc_pkg::*;;
  logic clk = 1'h0, rstn = 1'h0, wr = 1'h0, rd = 1'h0, fail = 1'h0, sb = 1'h0;
  logic ee = 1'h0, drq = 1'h0, fdn, fok, drd, nvq, nvs, nvd, irq;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h0000_0000, da = 32'h0000_0000, rdat, frd, u0, u1, got, a, d, old;
  logic [3:0] lat = 4'h1;
  logic [63:0] nvw;
  logic [15:0] nvp;
  fpc_fa_req_t fa;
  int failures = 0, check_count = 0, seed = 76333;
  logic [31:0] ta [5] = '{32'h0000_0402, 32'h0000_2000, 32'h0000_0404, 32'h0000_0408,
    32'h0000_0800};
  int tc [5] = '{CMD_PROG, CMD_PROG, CMD_ERASE, CMD_PROG, CMD_ERASE};
  logic [31:0] te [5] = '{32'h0000_0040, 32'h0000_0040, 32'h0000_0020, 32'h0000_0042,
    32'h0000_0022};
  always #10 clk = ~clk;
  fpc_ctrl dut_u (.clk(clk), .rstn(rstn), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata_r(rdat), .fa_r(fa), .fa_rdata(frd), .fa_done(fdn), .fa_ok(fok),
    .supply_bad(sb), .ee_irq(ee), .dr_req(drq), .dr_addr(da), .dr_deny_r(drd),
    .nv_req_r(nvq), .nv_sel_r(nvs), .nv_wdata_r(nvw), .nv_done(nvd), .nv_prot(nvp),
    .nv_user0(u0), .nv_user1(u1), .irq_r(irq));
  fpc_flash_model mdl_u (.clk(clk), .fa(fa), .fail(fail), .lat(lat), .fa_rdata(frd),
    .fa_done(fdn), .fa_ok(fok), .nv_req(nvq), .nv_sel(nvs), .nv_wdata(nvw), .nv_done(nvd),
    .nv_prot(nvp), .nv_user0(u0), .nv_user1(u1));
  // stored word after a program: refused if any bit would rise
  function automatic logic [31:0] exp_word(input logic [31:0] o, n);
    return ((n & ~o) != 32'h0000_0000) ? o : n;
  endfunction
  function automatic logic [31:0] exp_raw(input logic [31:0] o, n);
    return ((n & ~o) != 32'h0000_0000) ? 32'h0000_0010 : 32'h0000_0002;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // bus cycles: each leaves one idle edge so strobes never double up
  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] dt);
    ra <= ad;
    wd <= dt;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask
  // plain read into got, data taken in the cycle after the strobe
  task automatic rdv(input logic [7:0] ad);
    ra <= ad;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 got = rdat;
    @(posedge clk);
  endtask
  task automatic rchk(input string n, input logic [7:0] ad, input logic [31:0] e);
    rdv(ad);
    chk(n, e, got);
  endtask
  task automatic op(input logic [31:0] ad, dt, input int b);
    wr_reg(REG_ADDR, ad);
    wr_reg(REG_DATA, dt);
    wr_reg(REG_CMD, 32'h0000_0001 << b);
    for (int i = 0; i < 60; i++) begin
      rdv(REG_STAT);
      if (got[STAT_BUSY] === 1'h0) return;
    end
    failures++;
    conclude();
  endtask
  task automatic dread(input logic [31:0] ad, input logic e);
    drq <= 1'h1;
    da <= ad;
    @(posedge clk);
    drq <= 1'h0;
    #1 chk("deny", e, drd);
    @(posedge clk);
  endtask
  task automatic rst(input int n);
    rstn <= 1'h0;
    repeat (n) @(posedge clk);
    rstn <= 1'h1;
    repeat (2) @(posedge clk);
  endtask
  // main sequence
  initial begin
    rst(4);
    rchk("prot", REG_PROT, 32'h0000_4000);
    rchk("user0", REG_USER0, 32'h0000_00A5);
    rchk("hole", 8'h2C, 32'h0000_0000);
    wr_reg(REG_IEN, 32'h0000_007F);
    op(32'h0000_0400, 32'h0000_0000, CMD_ERASE);
    chk("erase", 32'hFFFF_FFFF, mdl_u.mem[256]);
    rchk("raw", REG_RAW, 32'h0000_0002);
    chk("irq", 32'h0000_0001, irq);
    for (int i = 0; i < 16; i++) begin
      a = 32'h0000_0400 | (32'h0000_000C & $random(seed));
      old = mdl_u.mem[a[12:2]];
      d = i[0] ? old & $random(seed) : $random(seed);
      wr_reg(REG_ICLR, 32'h0000_007F);
      op(a, d, CMD_PROG);
      chk("word", exp_word(old, d), mdl_u.mem[a[12:2]]);
      rchk("raw", REG_RAW, exp_raw(old, d));
    end
    for (int i = 0; i < 5; i++) begin
      fail <= i > 2;
      wr_reg(REG_ICLR, 32'h0000_007F);
      op(ta[i], 32'h0000_0000, tc[i]);
      rchk("refused", REG_RAW, te[i]);
    end
    rchk("stat", REG_STAT, 32'h0000_0006);
    fail <= 1'h0;
    wr_reg(REG_ICLR, 32'h0000_007F);
    wr_reg(REG_PROT, 32'h0000_0101);
    old = mdl_u.mem[256];
    op(32'h0000_0400, 32'h0000_0000, CMD_PROG);
    chk("kept", old, mdl_u.mem[256]);
    rchk("raw", REG_RAW, 32'h0000_0001);
    wr_reg(REG_PROT, 32'h0000_0100);
    rchk("loosen", REG_PROT, 32'h0000_4004);
    wr_reg(REG_PROT, 32'h0000_0102);
    rchk("tighten", REG_PROT, 32'h0000_4008);
    wr_reg(REG_PROT, 32'h0000_0101);
    rchk("fixed", REG_PROT, 32'h0000_4008);
    wr_reg(REG_ICLR, 32'h0000_007F);
    dread(32'h0000_0404, 1'h1);
    rchk("raw", REG_RAW, 32'h0000_0001);
    dread(32'h0000_0004, 1'h0);
    // supply drops while a slow erase runs
    lat <= 4'hF;
    wr_reg(REG_ICLR, 32'h0000_007F);
    op(32'h0000_0C00, 32'h0000_0000, 32);
    wr_reg(REG_CMD, 32'h0000_0002);
    sb <= 1'h1;
    op(32'h0000_0C00, 32'h0000_0000, 32);
    sb <= 1'h0;
    lat <= 4'h1;
    rchk("raw", REG_RAW, 32'h0000_0008);
    wr_reg(REG_IEN, 32'h0000_0000);
    wr_reg(REG_ICLR, 32'h0000_007F);
    ee <= 1'h1;
    @(posedge clk);
    ee <= 1'h0;
    rchk("raw", REG_RAW, 32'h0000_0004);
    chk("irq", 32'h0000_0000, irq);
    wr_reg(REG_IEN, 32'h0000_0004);
    rchk("masked", REG_MASKED, 32'h0000_0004);
    chk("irq", 32'h0000_0001, irq);
    wr_reg(REG_ICLR, 32'h0000_0004);
    rchk("raw", REG_RAW, 32'h0000_0000);
    chk("irq", 32'h0000_0000, irq);
    wr_reg(REG_USER0, 32'h1357_9BDF);
    wr_reg(REG_USER1, 32'h2468_ACE0);
    rchk("user1", REG_USER1, 32'h2468_ACE0);
    op(32'h0000_0000, 32'h0000_0000, CMD_USAVE);
    chk("stored", 32'h1357_9BDF, mdl_u.nv_user0);
    rchk("stat", REG_STAT, 32'h0000_000A);
    wr_reg(REG_USER0, 32'h0000_0000);
    rchk("user0", REG_USER0, 32'h1357_9BDF);
    rst(2);
    rchk("revert", REG_PROT, 32'h0000_4000);
    wr_reg(REG_PROT, 32'h0000_0301);
    op(32'h0000_0000, 32'h0000_0000, CMD_PSAVE);
    chk("saved", 32'h0000_4040, {16'h0000, mdl_u.nv_prot});
    rst(2);
    rchk("commit", REG_PROT, 32'h0000_4040);
    conclude();
  end
endmodule

// File: verilog/fpc_ctrl.sv
// flash protect/program controller: register port, sequencer, protection
// assumes a flash array macro with combinational read of fa.addr,
// a nonvolatile store presenting committed values at reset release
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
module fpc_ctrl import fpc_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_r,
  output fpc_fa_req_t fa_r,
  input wire logic [31:0] fa_rdata,
  input wire logic fa_done,
  input wire logic fa_ok,
  input wire logic supply_bad,
  input wire logic ee_irq,
  input wire logic dr_req,
  input wire logic [31:0] dr_addr,
  output logic dr_deny_r,
  output logic nv_req_r,
  output logic nv_sel_r,
  output logic [63:0] nv_wdata_r,
  input wire logic nv_done,
  input wire logic [2*NBLK-1:0] nv_prot,
  input wire logic [31:0] nv_user0,
  input wire logic [31:0] nv_user1,
  output logic irq_r
);
  typedef enum logic [4:0] {
    ST_LOAD = 5'b00001,
    ST_IDLE = 5'b00010,
    ST_CHECK = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_NV = 5'b10000
  } fpc_state_t;

  typedef struct packed {
    fpc_state_t st;
    logic [31:0] addr;
    logic [31:0] data;
    logic [2*NBLK-1:0] prot;
    logic [31:0] user0;
    logic [31:0] user1;
    logic ulock;
    logic busy;
    logic done;
    logic err;
    logic [NFLAG-1:0] ien;
    fpc_fa_req_t fa;
    logic nv_req;
    logic nv_sel;
    logic [63:0] nv_wdata;
    logic [31:0] rdata;
    logic dr_deny;
  } fpc_ctrl_t;

  fpc_ctrl_t q_r, q_nxt;
  logic [NFLAG-1:0] fset;
  logic [NFLAG-1:0] fclr;
  logic [NFLAG-1:0] raw;
  logic vbad;
  logic [1:0] lvl_cmd;
  logic [1:0] lvl_dr;
  logic [BLK_W-1:0] pblk;
  logic [1:0] pcur;
  logic [1:0] pnew;

  // supply monitor is an outside level
  fpc_sync3 u_vsync (
    .clk(clk),
    .rstn(rstn),
    .din(supply_bad),
    .dout_r(vbad)
  );

  // sticky flags, mask and interrupt line
  fpc_irq_flags u_flags (
    .clk(clk),
    .rstn(rstn),
    .set(fset),
    .clr(fclr),
    .en(q_r.ien),
    .raw_r(raw),
    .irq_r(irq_r)
  );

  // protection levels of the addressed blocks
  assign lvl_cmd = q_r.prot[2*fpc_blk(q_r.addr) +: 2];
  assign lvl_dr = q_r.prot[2*fpc_blk(dr_addr) +: 2];
  assign pblk = reg_wdata[PROT_BLK_LSB +: BLK_W];
  assign pcur = q_r.prot[2*pblk +: 2];
  assign pnew = reg_wdata[1:0];

  always_comb begin
    q_nxt = q_r;
    fset = '0;
    fclr = '0;
    q_nxt.fa.req = 1'b0;
    q_nxt.fa.abort = 1'b0;
    q_nxt.nv_req = 1'b0;
    q_nxt.rdata = RESET_WORD;

    // eeprom event forwarded
    fset[FL_EEPROM] = ee_irq; // R3

    // data reads of fetch-only blocks are refused
    q_nxt.dr_deny = dr_req && (lvl_dr == PROTECT_LEVEL_FETCH_ONLY); // R10 R12
    if (q_nxt.dr_deny) begin
      fset[FL_ACCESS] = 1'b1; // R10
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        REG_ADDR: q_nxt.addr = reg_wdata;
        REG_DATA: q_nxt.data = reg_wdata;
        REG_IEN: q_nxt.ien = reg_wdata[NFLAG-1:0]; // R8
        REG_ICLR: fclr = reg_wdata[NFLAG-1:0]; // R22
        REG_PROT: begin
          // only tightening is accepted, anything else leaves the level
          if (pnew <= PROTECT_LEVEL_FETCH_ONLY && pnew >= pcur) begin // R13 R14
            q_nxt.prot[2*pblk +: 2] = pnew;
          end
        end
        REG_USER0: begin
          if (!q_r.ulock) begin // R17 R18
            q_nxt.user0 = reg_wdata;
          end
        end
        REG_USER1: begin
          if (!q_r.ulock) begin // R17 R18
            q_nxt.user1 = reg_wdata;
          end
        end
        default: begin
        end
      endcase
    end

    // register reads, data stand one cycle
    if (reg_rd) begin
      case (reg_addr)
        REG_ADDR: q_nxt.rdata = q_r.addr;
        REG_DATA: q_nxt.rdata = q_r.data;
        REG_STAT: begin
          q_nxt.rdata[STAT_BUSY] = q_r.busy; // R19
          q_nxt.rdata[STAT_DONE] = q_r.done; // R19
          q_nxt.rdata[STAT_ERR] = q_r.err;
          q_nxt.rdata[STAT_ULOCK] = q_r.ulock;
        end
        REG_RAW: q_nxt.rdata[NFLAG-1:0] = raw; // R9
        REG_MASKED: q_nxt.rdata[NFLAG-1:0] = raw & q_r.ien; // R9
        REG_IEN: q_nxt.rdata[NFLAG-1:0] = q_r.ien;
        REG_PROT: q_nxt.rdata[2*NBLK-1:0] = q_r.prot;
        REG_USER0: q_nxt.rdata = q_r.user0;
        REG_USER1: q_nxt.rdata = q_r.user1;
        default: q_nxt.rdata = RESET_WORD;
      endcase
    end

    // sequencer
    case (q_r.st)
      ST_LOAD: begin
        // committed values come back after every reset
        q_nxt.prot = nv_prot; // R15
        q_nxt.user0 = nv_user0;
        q_nxt.user1 = nv_user1;
        q_nxt.st = ST_IDLE;
      end
      ST_IDLE: begin
        if (reg_wr && reg_addr == REG_CMD) begin
          q_nxt.done = 1'b0;
          q_nxt.err = 1'b0;
          q_nxt.fa.addr = q_r.addr;
          if (reg_wdata[CMD_PROG]) begin
            q_nxt.fa.erase = 1'b0;
            if (!fpc_in_range(q_r.addr) || q_r.addr[1:0] != 2'h0) begin // R11
              fset[FL_PROG] = 1'b1;
              q_nxt.err = 1'b1;
              q_nxt.done = 1'b1;
            end else if (lvl_cmd != PROTECT_LEVEL_OPEN) begin
              fset[FL_ACCESS] = 1'b1; // R1 R12
              q_nxt.err = 1'b1;
              q_nxt.done = 1'b1;
            end else begin
              q_nxt.busy = 1'b1; // R19
              q_nxt.st = ST_CHECK;
            end
          end else if (reg_wdata[CMD_ERASE]) begin
            q_nxt.fa.erase = 1'b1;
            if (!fpc_in_range(q_r.addr) || q_r.addr[BLK_LSB-1:0] != 10'h000) begin
              fset[FL_ERASE] = 1'b1; // R23
              q_nxt.err = 1'b1;
              q_nxt.done = 1'b1;
            end else if (lvl_cmd != PROTECT_LEVEL_OPEN) begin
              fset[FL_ACCESS] = 1'b1; // R1 R12
              q_nxt.err = 1'b1;
              q_nxt.done = 1'b1;
            end else begin
              // array fills the whole block with ones
              q_nxt.fa.req = 1'b1; // R20
              q_nxt.busy = 1'b1;
              q_nxt.st = ST_WAIT;
            end
          end else if (reg_wdata[CMD_PSAVE]) begin
            q_nxt.nv_req = 1'b1; // R16
            q_nxt.nv_sel = 1'b0;
            q_nxt.nv_wdata = {48'h0000_0000_0000, q_r.prot};
            q_nxt.busy = 1'b1;
            q_nxt.st = ST_NV;
          end else if (reg_wdata[CMD_USAVE]) begin
            q_nxt.nv_req = 1'b1; // R18
            q_nxt.nv_sel = 1'b1;
            q_nxt.nv_wdata = {q_r.user1, q_r.user0};
            q_nxt.busy = 1'b1;
            q_nxt.st = ST_NV;
          end
        end
      end
      ST_CHECK: begin
        // a stored 0 must never be asked to become 1
        if (|(~fa_rdata & q_r.data)) begin
          fset[FL_DATA] = 1'b1; // R5
          q_nxt.err = 1'b1;
          q_nxt.done = 1'b1;
          q_nxt.busy = 1'b0;
          q_nxt.st = ST_IDLE;
        end else begin
          q_nxt.fa.wdata = q_r.data & fa_rdata; // R21
          q_nxt.fa.req = 1'b1;
          q_nxt.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (vbad) begin
          q_nxt.fa.abort = 1'b1; // R4
          fset[FL_VOLT] = 1'b1; // R4
          q_nxt.err = 1'b1;
          q_nxt.done = 1'b1;
          q_nxt.busy = 1'b0;
          q_nxt.st = ST_IDLE;
        end else if (fa_done) begin
          fset[FL_DONE] = 1'b1; // R2
          if (!fa_ok) begin
            q_nxt.err = 1'b1;
            if (q_r.fa.erase) begin
              fset[FL_ERASE] = 1'b1; // R6
            end else begin
              fset[FL_PROG] = 1'b1; // R7
            end
          end
          q_nxt.done = 1'b1; // R19
          q_nxt.busy = 1'b0;
          q_nxt.st = ST_IDLE;
        end
      end
      ST_NV: begin
        if (nv_done) begin
          q_nxt.done = 1'b1; // R16 R18
          q_nxt.busy = 1'b0;
          if (q_r.nv_sel) begin
            q_nxt.ulock = 1'b1; // R18
          end
          q_nxt.st = ST_IDLE;
        end
      end
      default: q_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= '0;
      q_r.st <= ST_LOAD;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata_r = q_r.rdata;
  assign fa_r = q_r.fa;
  assign dr_deny_r = q_r.dr_deny;
  assign nv_req_r = q_r.nv_req;
  assign nv_sel_r = q_r.nv_sel;
  assign nv_wdata_r = q_r.nv_wdata;
endmodule

// File: verilog/fpc_irq_flags.sv
// sticky interrupt flags with enable mask and one interrupt line
// assumes set and clear pulses come from the same clock domain
`timescale 1ns/1ps
module fpc_irq_flags import fpc_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [NFLAG-1:0] set,
  input wire logic [NFLAG-1:0] clr,
  input wire logic [NFLAG-1:0] en,
  output logic [NFLAG-1:0] raw_r,
  output logic irq_r
);
  typedef struct packed {
    logic [NFLAG-1:0] raw;
    logic irq;
  } fpc_flag_t;

  fpc_flag_t q_r, q_nxt;

  // set wins over a clear in the same cycle
  always_comb begin
    q_nxt.raw = (q_r.raw & ~clr) | set; // R22
    q_nxt.irq = |(q_nxt.raw & en); // R8
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign raw_r = q_r.raw;
  assign irq_r = q_r.irq;
endmodule

// File: verilog/fpc_sync3.sv
// three-stage synchroniser for one asynchronous level
// assumes the input is a pin outside the clk domain
`timescale 1ns/1ps
module fpc_sync3 import fpc_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic din,
  output logic dout_r
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } fpc_sync_t;

  fpc_sync_t q_r, q_nxt;

  // change counts once stages two and three agree
  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = din;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    if (q_r.s2 == q_r.s3) begin
      q_nxt.out = q_r.s3;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign dout_r = q_r.out;
endmodule
